//--- bte_exec.sv
// bit, shift, flag and data transfer execution unit
`timescale 1ns/1ps
`default_nettype none

module bte_exec
  import bte_pkg::*;
#(
  parameter int IO_AW = 6,
  parameter logic [15:0] SP_INIT = SP_RESET
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // decoded instruction
  input wire logic op_valid,
  input wire bte_op_e op_code,
  input wire logic [4:0] op_rd,
  input wire logic [4:0] op_rr,
  input wire logic [2:0] op_bit,
  input wire bte_ptr_e op_ptr,
  input wire bte_mode_e op_mode,
  input wire logic op_implicit,
  input wire logic [15:0] op_imm,
  output logic op_ready,
  output logic op_done,
  // data memory and stack
  output logic [15:0] dmem_addr,
  output logic [7:0] dmem_wdata,
  output logic dmem_we,
  output logic dmem_re,
  input wire logic [7:0] dmem_rdata,
  // io registers
  output logic [IO_AW-1:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_we,
  output logic io_re,
  input wire logic [7:0] io_rdata,
  // program memory
  output logic [15:0] pmem_addr,
  output logic pmem_re,
  output logic pmem_we,
  output logic [15:0] pmem_wdata,
  input wire logic [7:0] pmem_rdata,
  input wire logic pmem_done,
  // status
  output logic [7:0] status_register
);

  typedef enum logic [2:0] {S_IDLE, S_MEM, S_CODE1, S_CODE2, S_WRITE} bte_state_e;

  logic [7:0] rf_q [REG_N];
  bte_state_e st_q;
  bte_op_e cur_op_q;
  logic [4:0] cur_rd_q;
  logic [2:0] cur_bit_q;
  logic rdy_q, done_q;
  logic pend_q;
  logic [4:0] pend_idx_q;
  logic [15:0] sp_q;
  logic [7:0] status_register_q;
  logic [15:0] dmem_addr_q;
  logic [7:0] dmem_wdata_q;
  logic dmem_we_q, dmem_re_q;
  logic [IO_AW-1:0] io_addr_q;
  logic [7:0] io_wdata_q;
  logic io_we_q, io_re_q;
  logic [15:0] pmem_addr_q, pmem_wdata_q;
  logic pmem_re_q, pmem_we_q;

  // register read with bypass of a pending io input
  function automatic logic [7:0] rd_reg(input logic [4:0] idx);
    logic [7:0] v;
    v = rf_q[idx];
    if (pend_q && pend_idx_q == idx) begin
      v = io_rdata;
    end
    return v;
  endfunction

  logic acc;
  logic [7:0] a_d, r_d;
  logic [4:0] ptr_lo, ptr_hi;
  logic [15:0] ptr_v, ptr_nv, ea, z_v;
  logic ptr_en;
  logic [7:0] sh_res;
  logic sh_c;
  logic w1_en, w2_en, w3_en;
  logic [4:0] w1_idx, w2_idx;
  logic [7:0] w1_dat, w2_dat;

  assign acc = op_valid && rdy_q;
  // operand reads follow register file and bypass changes
  always_comb begin
    a_d = rd_reg(op_rd);
    r_d = rd_reg(op_rr);
    z_v = {rd_reg(Z_LO + HI_STEP), rd_reg(Z_LO)};
  end
  assign w3_en = pend_q;

  // pointer pair selection and effective address
  always_comb begin
    case (op_ptr)
      PTR_X: ptr_lo = X_LO;
      PTR_Y: ptr_lo = Y_LO;
      default: ptr_lo = Z_LO;
    endcase
    if (op_code == OP_CODE_READ) begin
      ptr_lo = Z_LO;
    end
    ptr_hi = ptr_lo + HI_STEP;
    ptr_v = {rd_reg(ptr_hi), rd_reg(ptr_lo)};
    ptr_nv = ptr_v;
    ptr_en = 1'b0;
    if (acc && (op_code == OP_INDIRECT_READ || op_code == OP_MEMORY_WRITE ||
                op_code == OP_CODE_READ)) begin
      if (op_mode == MODE_POST_INC) begin
        ptr_nv = ptr_v + PTR_STEP;
        ptr_en = 1'b1;
      end else if (op_mode == MODE_PRE_DEC && op_code != OP_CODE_READ) begin
        ptr_nv = ptr_v - PTR_STEP;
        ptr_en = 1'b1;
      end
    end
    case (op_code)
      OP_OFFSET_READ, OP_OFFSET_WRITE: ea = ptr_v + op_imm;
      OP_DIRECT_READ, OP_DIRECT_WRITE: ea = op_imm;
      default: ea = (op_mode == MODE_PRE_DEC) ? ptr_nv : ptr_v;
    endcase
  end

  // shift and rotate datapath
  always_comb begin
    sh_res = a_d;
    sh_c = status_register_q[FLAG_C];
    case (op_code)
      OP_SHIFT_LEFT_ZERO: begin
        sh_res = {a_d[6:0], 1'b0};
        sh_c = a_d[7];
      end
      OP_CARRY_ROTATE_LEFT: begin
        sh_res = {a_d[6:0], status_register_q[FLAG_C]};
        sh_c = a_d[7];
      end
      OP_SHIFT_RIGHT_ZERO: begin
        sh_res = {1'b0, a_d[7:1]};
        sh_c = a_d[0];
      end
      OP_CARRY_ROTATE_RIGHT: begin
        sh_res = {status_register_q[FLAG_C], a_d[7:1]};
        sh_c = a_d[0];
      end
      OP_SIGN_SHIFT_RIGHT: begin
        sh_res = {a_d[7], a_d[7:1]};
        sh_c = a_d[0];
      end
      default: begin
      end
    endcase
  end

  // register file write ports
  always_comb begin
    w1_en = 1'b0;
    w1_idx = op_rd;
    w1_dat = sh_res;
    w2_en = 1'b0;
    w2_idx = op_rd | HI_STEP;
    w2_dat = rd_reg(op_rr | HI_STEP);
    if (acc) begin
      case (op_code)
        OP_SHIFT_LEFT_ZERO, OP_CARRY_ROTATE_LEFT, OP_SHIFT_RIGHT_ZERO,
        OP_CARRY_ROTATE_RIGHT, OP_SIGN_SHIFT_RIGHT: w1_en = 1'b1;
        OP_FLAG_DEPOSIT_BIT: begin
          w1_en = 1'b1;
          w1_dat = a_d;
          w1_dat[op_bit] = status_register_q[FLAG_T];
        end
        OP_MOVE: begin
          w1_en = 1'b1;
          w1_dat = r_d;
        end
        OP_PAIR_COPY: begin
          w1_en = 1'b1;
          w1_idx = op_rd & ~HI_STEP;
          w1_dat = rd_reg(op_rr & ~HI_STEP);
          w2_en = 1'b1;
        end
        OP_IMMEDIATE_LOAD: begin
          w1_en = 1'b1;
          w1_dat = op_imm[7:0];
        end
        default: begin
        end
      endcase
    end else if (st_q == S_MEM && (cur_op_q == OP_INDIRECT_READ ||
                 cur_op_q == OP_OFFSET_READ || cur_op_q == OP_DIRECT_READ ||
                 cur_op_q == OP_POP)) begin
      w1_en = 1'b1;
      w1_idx = cur_rd_q;
      w1_dat = dmem_rdata;
    end else if (st_q == S_CODE2) begin
      w1_en = 1'b1;
      w1_idx = cur_rd_q;
      w1_dat = pmem_rdata;
    end
  end

  for (genvar gi = 0; gi < REG_N; gi++) begin : g_rf
    always_ff @(posedge clk) begin
      if (!nrst) begin
        rf_q[gi] <= RF_RESET;
      end else if (w1_en && w1_idx == 5'(gi)) begin
        rf_q[gi] <= w1_dat;
      end else if (w2_en && w2_idx == 5'(gi)) begin
        rf_q[gi] <= w2_dat;
      end else if (w3_en && pend_idx_q == 5'(gi)) begin
        rf_q[gi] <= io_rdata;
      end else if (ptr_en && ptr_lo == 5'(gi)) begin
        rf_q[gi] <= ptr_nv[7:0];
      end else if (ptr_en && ptr_hi == 5'(gi)) begin
        rf_q[gi] <= ptr_nv[15:8];
      end
    end
  end

  // sequencer: ready, done and latched operation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      rdy_q <= 1'b1;
      done_q <= 1'b0;
      cur_op_q <= OP_NOP;
      cur_rd_q <= R0_IDX;
      cur_bit_q <= FLAG_C;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (acc) begin
            cur_op_q <= op_code;
            cur_rd_q <= (op_code == OP_CODE_READ && op_implicit) ? R0_IDX : op_rd;
            cur_bit_q <= op_bit;
            case (op_code)
              OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_INDIRECT_READ, OP_OFFSET_READ,
              OP_DIRECT_READ, OP_MEMORY_WRITE, OP_OFFSET_WRITE, OP_DIRECT_WRITE,
              OP_PUSH, OP_POP: begin
                st_q <= S_MEM;
                rdy_q <= 1'b0;
              end
              OP_CODE_READ: begin
                st_q <= S_CODE1;
                rdy_q <= 1'b0;
              end
              OP_CODE_WRITE: begin
                st_q <= S_WRITE;
                rdy_q <= 1'b0;
              end
              default: done_q <= 1'b1;
            endcase
          end
        end
        S_MEM, S_CODE2: begin
          st_q <= S_IDLE;
          rdy_q <= 1'b1;
          done_q <= 1'b1;
        end
        S_CODE1: st_q <= S_CODE2;
        S_WRITE: begin
          if (pmem_done) begin
            st_q <= S_IDLE;
            rdy_q <= 1'b1;
            done_q <= 1'b1;
          end
        end
        default: begin
          st_q <= S_IDLE;
          rdy_q <= 1'b1;
        end
      endcase
    end
  end

  // data memory and stack access
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dmem_addr_q <= SP_RESET;
      dmem_wdata_q <= RF_RESET;
      dmem_we_q <= 1'b0;
      dmem_re_q <= 1'b0;
      sp_q <= SP_INIT;
    end else begin
      dmem_we_q <= 1'b0;
      if (st_q == S_MEM) begin
        dmem_re_q <= 1'b0;
      end
      if (acc) begin
        case (op_code)
          OP_INDIRECT_READ, OP_OFFSET_READ, OP_DIRECT_READ: begin
            dmem_addr_q <= ea;
            dmem_re_q <= 1'b1;
          end
          OP_MEMORY_WRITE, OP_OFFSET_WRITE, OP_DIRECT_WRITE: begin
            dmem_addr_q <= ea;
            dmem_wdata_q <= a_d;
            dmem_we_q <= 1'b1;
          end
          OP_PUSH: begin
            dmem_addr_q <= sp_q;
            dmem_wdata_q <= a_d;
            dmem_we_q <= 1'b1;
            sp_q <= sp_q - PTR_STEP;
          end
          OP_POP: begin
            dmem_addr_q <= sp_q + PTR_STEP;
            dmem_re_q <= 1'b1;
            sp_q <= sp_q + PTR_STEP;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // io register access
  always_ff @(posedge clk) begin
    if (!nrst) begin
      io_addr_q <= '0;
      io_wdata_q <= RF_RESET;
      io_we_q <= 1'b0;
      io_re_q <= 1'b0;
      pend_q <= 1'b0;
      pend_idx_q <= R0_IDX;
    end else begin
      io_we_q <= 1'b0;
      io_re_q <= 1'b0;
      pend_q <= 1'b0;
      if (acc && (op_code == OP_IO_BIT_SET || op_code == OP_IO_BIT_CLEAR ||
                  op_code == OP_IO_IN)) begin
        io_addr_q <= op_imm[IO_AW-1:0];
        io_re_q <= 1'b1;
        pend_q <= (op_code == OP_IO_IN);
        pend_idx_q <= op_rd;
      end else if (acc && op_code == OP_IO_OUT) begin
        io_addr_q <= op_imm[IO_AW-1:0];
        io_wdata_q <= a_d;
        io_we_q <= 1'b1;
      end else if (st_q == S_MEM && cur_op_q == OP_IO_BIT_SET) begin
        io_wdata_q <= io_rdata | (8'h01 << cur_bit_q);
        io_we_q <= 1'b1;
      end else if (st_q == S_MEM && cur_op_q == OP_IO_BIT_CLEAR) begin
        io_wdata_q <= io_rdata & ~(8'h01 << cur_bit_q);
        io_we_q <= 1'b1;
      end
    end
  end

  // program memory access
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pmem_addr_q <= '0;
      pmem_wdata_q <= '0;
      pmem_re_q <= 1'b0;
      pmem_we_q <= 1'b0;
    end else begin
      if (acc && op_code == OP_CODE_READ) begin
        pmem_addr_q <= z_v;
        pmem_re_q <= 1'b1;
      end else if (st_q == S_CODE2) begin
        pmem_re_q <= 1'b0;
      end
      if (acc && op_code == OP_CODE_WRITE) begin
        pmem_addr_q <= z_v;
        pmem_wdata_q <= {rd_reg(R1_IDX), rd_reg(R0_IDX)};
        pmem_we_q <= 1'b1;
      end else if (st_q == S_WRITE && pmem_done) begin
        pmem_we_q <= 1'b0;
      end
    end
  end

  // status register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_register_q <= STATUS_REGISTER_RESET;
    end else if (acc) begin
      case (op_code)
        OP_SHIFT_LEFT_ZERO, OP_CARRY_ROTATE_LEFT, OP_SHIFT_RIGHT_ZERO,
        OP_CARRY_ROTATE_RIGHT, OP_SIGN_SHIFT_RIGHT: begin
          status_register_q[FLAG_C] <= sh_c;
          status_register_q[FLAG_Z] <= (sh_res == RF_RESET);
          status_register_q[FLAG_N] <= sh_res[7];
          status_register_q[FLAG_V] <= sh_res[7] ^ sh_c;
        end
        OP_FLAG_CAPTURE_BIT: status_register_q[FLAG_T] <= r_d[op_bit];
        OP_STATUS_FLAG_RAISE: status_register_q[op_bit] <= 1'b1;
        OP_STATUS_FLAG_LOWER: status_register_q[op_bit] <= 1'b0;
        default: begin
        end
      endcase
    end
  end

  assign op_ready = rdy_q;
  assign op_done = done_q;
  assign dmem_addr = dmem_addr_q;
  assign dmem_wdata = dmem_wdata_q;
  assign dmem_we = dmem_we_q;
  assign dmem_re = dmem_re_q;
  assign io_addr = io_addr_q;
  assign io_wdata = io_wdata_q;
  assign io_we = io_we_q;
  assign io_re = io_re_q;
  assign pmem_addr = pmem_addr_q;
  assign pmem_re = pmem_re_q;
  assign pmem_we = pmem_we_q;
  assign pmem_wdata = pmem_wdata_q;
  assign status_register = status_register_q;

endmodule

`default_nettype wire

//--- bte_pkg.sv
// constants and types for the bit and transfer execution unit
package bte_pkg;

  localparam int REG_N = 32;
  localparam logic [4:0] R0_IDX = 5'h00;
  localparam logic [4:0] R1_IDX = 5'h01;
  localparam logic [4:0] X_LO = 5'h1a;
  localparam logic [4:0] Y_LO = 5'h1c;
  localparam logic [4:0] Z_LO = 5'h1e;
  localparam logic [4:0] HI_STEP = 5'h01;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // status register bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  localparam logic [7:0] STATUS_REGISTER_RESET = 8'h00;
  localparam logic [7:0] RF_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'hffff;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} bte_ptr_e;
  typedef enum logic [1:0] {MODE_PLAIN, MODE_POST_INC, MODE_PRE_DEC} bte_mode_e;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_SHIFT_LEFT_ZERO, OP_CARRY_ROTATE_LEFT,
    OP_SHIFT_RIGHT_ZERO, OP_CARRY_ROTATE_RIGHT, OP_SIGN_SHIFT_RIGHT,
    OP_FLAG_CAPTURE_BIT, OP_FLAG_DEPOSIT_BIT,
    OP_STATUS_FLAG_RAISE, OP_STATUS_FLAG_LOWER,
    OP_MOVE, OP_PAIR_COPY, OP_IMMEDIATE_LOAD,
    OP_INDIRECT_READ, OP_OFFSET_READ, OP_DIRECT_READ,
    OP_MEMORY_WRITE, OP_OFFSET_WRITE, OP_DIRECT_WRITE,
    OP_CODE_READ, OP_CODE_WRITE,
    OP_IO_IN, OP_IO_OUT, OP_PUSH, OP_POP
  } bte_op_e;

endpackage

//--- bte_exec_props.sv
// port assertions for the bit and transfer execution unit
`timescale 1ns/1ps
`default_nettype none
module bte_exec_props
  import bte_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction port
  input wire logic op_valid,
  input wire bte_op_e op_code,
  input wire logic [2:0] op_bit,
  input wire logic op_ready,
  input wire logic op_done,
  // strobes and status
  input wire logic dmem_we,
  input wire logic dmem_re,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic pmem_re,
  input wire logic [7:0] status_register
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic tk;
  assign tk = op_valid && op_ready;
  sequence s_mem;
    ##1 ((dmem_we || dmem_re) && !op_ready) ##1 (op_done && op_ready);
  endsequence
  sequence s_io;
    ##1 io_re ##1 (io_we && op_done);
  endsequence
  a_io_set_seq: assert property (tk && op_code == OP_IO_BIT_SET |-> s_io)
    else $error("io bit set timing wrong");
  a_io_clear_seq: assert property (tk && op_code == OP_IO_BIT_CLEAR |-> s_io)
    else $error("io bit clear timing wrong");
  a_single_cycle_op: assert property (tk && op_code inside {[OP_SHIFT_LEFT_ZERO:
    OP_IMMEDIATE_LOAD], OP_IO_IN, OP_IO_OUT} |=> op_done && op_ready)
    else $error("one cycle op not done in one cycle");
  a_mem_two_cycle: assert property (tk && op_code inside {[OP_INDIRECT_READ:
    OP_DIRECT_WRITE], OP_PUSH, OP_POP} |-> s_mem)
    else $error("memory op not done in two cycles");
  a_mem_flags_kept: assert property (tk && op_code inside {[OP_INDIRECT_READ:
    OP_DIRECT_WRITE], OP_PUSH, OP_POP} |=> $stable(status_register)[*2])
    else $error("memory op changed a flag");
  a_code_read_len: assert property (tk && op_code == OP_CODE_READ
    |-> ##1 pmem_re[*2] ##1 op_done)
    else $error("code read not three cycles");
  a_shift_v_flag: assert property (tk && op_code inside {[OP_SHIFT_LEFT_ZERO:
    OP_SIGN_SHIFT_RIGHT]} |=> status_register[3] == (status_register[2] ^ status_register[0])
    && status_register[5:4] == $past(status_register[5:4]))
    else $error("shift flags wrong");
  a_capture_only_t: assert property (tk && op_code == OP_FLAG_CAPTURE_BIT
    |=> (status_register & 8'hbf) == ($past(status_register) & 8'hbf))
    else $error("capture changed another flag");
  a_raise_one_flag: assert property (tk && op_code == OP_STATUS_FLAG_RAISE
    |=> status_register == ($past(status_register) | (8'h01 << $past(op_bit))))
    else $error("raise flag wrong");
  a_lower_one_flag: assert property (tk && op_code == OP_STATUS_FLAG_LOWER
    |=> status_register == ($past(status_register) & ~(8'h01 << $past(op_bit))))
    else $error("lower flag wrong");
endmodule
bind bte_exec bte_exec_props bte_exec_props_i (.clk(clk), .nrst(nrst), .op_valid(op_valid),
  .op_code(op_code), .op_bit(op_bit), .op_ready(op_ready), .op_done(op_done),
  .dmem_we(dmem_we), .dmem_re(dmem_re), .io_we(io_we), .io_re(io_re), .pmem_re(pmem_re),
  .status_register(status_register));
`default_nettype wire

//--- bte_mem_model.sv
// data, io and code memory model facing the execution unit
`timescale 1ns/1ps
`default_nettype none
module bte_mem_model (
  // clock
  input wire logic clk,
  // data memory and stack
  input wire logic [15:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  input wire logic dmem_we,
  input wire logic dmem_re,
  output logic [7:0] dmem_rdata,
  // io registers
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  output logic [7:0] io_rdata,
  // program memory
  input wire logic [15:0] pmem_addr,
  input wire logic pmem_re,
  input wire logic pmem_we,
  output logic [7:0] pmem_rdata,
  output logic pmem_done
);
  logic [7:0] dm [256];
  logic [7:0] io [64];
  logic [7:0] pb;
  logic [1:0] wcnt_q;
  initial begin
    for (int i = 0; i < 256; i++) dm[i] = i[7:0] ^ 8'ha5;
    for (int i = 0; i < 64; i++) io[i] = i[7:0] ^ 8'h3c;
  end
  always @(posedge clk) begin
    if (dmem_we) dm[dmem_addr[7:0]] <= dmem_wdata;
    if (io_we) io[io_addr] <= io_wdata;
  end
  // data valid only while read strobe is high, inverted otherwise
  assign dmem_rdata = dmem_re ? dm[dmem_addr[7:0]] : ~dm[dmem_addr[7:0]];
  assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];
  assign pb = pmem_addr[7:0] + 8'h11;
  assign pmem_rdata = pmem_re ? pb : ~pb;
  // slow code write: ends on third cycle of the write strobe
  always @(posedge clk) wcnt_q <= (pmem_we && !pmem_done) ? wcnt_q + 2'h1 : 2'h0;
  assign pmem_done = pmem_we && wcnt_q == 2'h2;
endmodule
`default_nettype wire

//--- bte_exec_tb_top.sv
// self-checking testbench for the bit and transfer execution unit
`timescale 1ns/1ps
`default_nettype none
module bte_exec_tb_top;
  import bte_pkg::*;
  logic clk;
  logic nrst;
  logic op_valid;
  logic op_implicit;
  logic op_ready;
  logic op_done;
  bte_op_e op_code;
  bte_ptr_e op_ptr;
  bte_mode_e op_mode;
  logic [4:0] op_rd;
  logic [4:0] op_rr;
  logic [2:0] op_bit;
  logic [15:0] op_imm;
  logic [15:0] dmem_addr;
  logic [15:0] pmem_addr;
  logic [15:0] pmem_wdata;
  logic [15:0] wa;
  logic [7:0] dmem_wdata;
  logic [7:0] dmem_rdata;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [7:0] pmem_rdata;
  logic [7:0] status_register;
  logic [7:0] wd;
  logic [7:0] iw;
  logic dmem_we;
  logic dmem_re;
  logic io_we;
  logic io_re;
  logic pmem_re;
  logic pmem_we;
  logic pmem_done;
  logic [5:0] io_addr;
  logic [5:0] ia;
  logic [31:0] pw;
  int failures;
  int total_checks;
  bte_exec #(.IO_AW(6), .SP_INIT(16'hffff)) bte_exec_i (.clk(clk), .nrst(nrst),
    .op_valid(op_valid), .op_code(op_code),
    .op_rd(op_rd), .op_rr(op_rr), .op_bit(op_bit), .op_ptr(op_ptr), .op_mode(op_mode),
    .op_implicit(op_implicit), .op_imm(op_imm), .op_ready(op_ready), .op_done(op_done),
    .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
    .dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
    .io_re(io_re), .io_rdata(io_rdata), .pmem_addr(pmem_addr), .pmem_re(pmem_re),
    .pmem_we(pmem_we), .pmem_wdata(pmem_wdata), .pmem_rdata(pmem_rdata),
    .pmem_done(pmem_done), .status_register(status_register));
  bte_mem_model bte_mem_model_i (.clk(clk), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_we(dmem_we), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
    .pmem_addr(pmem_addr), .pmem_re(pmem_re), .pmem_we(pmem_we), .pmem_rdata(pmem_rdata),
    .pmem_done(pmem_done));
  always #50 clk = ~clk;
  // capture of the last write on each memory port
  always @(posedge clk) begin
    if (dmem_we) wa <= dmem_addr;
    if (dmem_we) wd <= dmem_wdata;
    if (io_we) iw <= io_wdata;
    if (io_we) ia <= io_addr;
    if (pmem_we) pw <= {pmem_addr, pmem_wdata};
  end
  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      failures++;
    end
  endtask
  task op(input bte_op_e c, input logic [4:0] d = 5'h10, input logic [4:0] r = 5'h11,
    input logic [2:0] b = 3'h0, input bte_mode_e m = MODE_PLAIN, input bte_ptr_e p = PTR_X,
    input logic [15:0] k = 16'h0000, input logic im = 1'b0);
    int n;
    op_valid = 1'b1;
    op_code = c;
    op_rd = d;
    op_rr = r;
    op_bit = b;
    op_mode = m;
    op_ptr = p;
    op_imm = k;
    op_implicit = im;
    @(posedge clk);
    #1;
    if (op_done !== 1'b1) op_valid = 1'b0;
    n = 0;
    while (op_done !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 20) begin
        failures++;
        conclude;
      end
    end
  endtask
  task gap;
    op_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task li(input logic [4:0] d, input logic [7:0] v);
    op(OP_IMMEDIATE_LOAD, .d(d), .k({8'h00, v}));
  endtask
  task pk(input logic [4:0] d, input logic [7:0] e);
    op(OP_IO_OUT, .d(d), .k(16'h003f));
    gap;
    chk("reg", {8'h00, e}, {8'h00, iw});
  endtask
  task cs(input logic [7:0] e);
    chk("status", {8'h00, e}, {8'h00, status_register});
  endtask
  task cw(input logic [15:0] a, input logic [7:0] d);
    chk("addr", a, wa);
    chk("data", {8'h00, d}, {8'h00, wd});
  endtask
  task t_flags;
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 16; i++) begin
      op(i < 8 ? OP_STATUS_FLAG_RAISE : OP_STATUS_FLAG_LOWER, .b(i[2:0]));
      e[i[2:0]] = i < 8;
      cs(e);
    end
  endtask
  task t_shift;
    li(5'h10, 8'h81);
    op(OP_SHIFT_LEFT_ZERO); cs(8'h09); pk(5'h10, 8'h02);
    op(OP_CARRY_ROTATE_LEFT); cs(8'h00); pk(5'h10, 8'h05);
    op(OP_CARRY_ROTATE_RIGHT); cs(8'h09); pk(5'h10, 8'h02);
    li(5'h10, 8'h85);
    op(OP_SIGN_SHIFT_RIGHT); cs(8'h05); pk(5'h10, 8'hc2);
    op(OP_SHIFT_RIGHT_ZERO); cs(8'h00); pk(5'h10, 8'h61);
    li(5'h10, 8'h80);
    op(OP_SHIFT_LEFT_ZERO); cs(8'h0b);
  endtask
  task t_bits;
    li(5'h12, 8'h04);
    op(OP_FLAG_CAPTURE_BIT, .r(5'h12), .b(3'h2)); cs(8'h4b);
    li(5'h13, 8'h01);
    op(OP_FLAG_DEPOSIT_BIT, .d(5'h13), .b(3'h7)); cs(8'h4b); pk(5'h13, 8'h81);
    op(OP_MOVE, .d(5'h14), .r(5'h13)); pk(5'h14, 8'h81);
    op(OP_PAIR_COPY, .d(5'h16), .r(5'h12)); pk(5'h16, 8'h04); pk(5'h17, 8'h81);
    op(OP_FLAG_CAPTURE_BIT, .r(5'h12), .b(3'h0)); cs(8'h0b);
  endtask
  task t_io;
    op(OP_IO_BIT_SET, .b(3'h1), .k(16'h0005)); gap; chk("io", 16'h003b, {8'h00, iw});
    chk("io addr", 16'h0005, {10'h000, ia});
    op(OP_IO_BIT_CLEAR, .b(3'h3), .k(16'h0005)); gap; chk("io", 16'h0033, {8'h00, iw});
    op(OP_IO_IN, .d(5'h15), .k(16'h0005)); pk(5'h15, 8'h33);
  endtask
  task t_ptr;
    li(5'h1a, 8'hff); li(5'h1b, 8'hff); li(5'h10, 8'haa);
    op(OP_MEMORY_WRITE, .m(MODE_POST_INC)); cw(16'hffff, 8'haa);
    li(5'h10, 8'hbb);
    op(OP_MEMORY_WRITE); cw(16'h0000, 8'hbb);
    op(OP_INDIRECT_READ, .d(5'h11), .m(MODE_PRE_DEC)); pk(5'h11, 8'haa);
    li(5'h1c, 8'h10); li(5'h1d, 8'h00);
    op(OP_INDIRECT_READ, .d(5'h11), .p(PTR_Y), .m(MODE_POST_INC)); pk(5'h11, 8'hb5);
    op(OP_OFFSET_READ, .d(5'h11), .p(PTR_Y), .k(16'h0002)); pk(5'h11, 8'hb6);
    op(OP_MEMORY_WRITE, .p(PTR_Y)); cw(16'h0011, 8'hbb);
    li(5'h1e, 8'h00); li(5'h1f, 8'h01);
    op(OP_MEMORY_WRITE, .p(PTR_Z), .m(MODE_PRE_DEC)); cw(16'h00ff, 8'hbb);
    op(OP_OFFSET_WRITE, .p(PTR_Z), .k(16'h0005)); cw(16'h0104, 8'hbb);
    op(OP_DIRECT_WRITE, .k(16'h1234)); cw(16'h1234, 8'hbb);
    op(OP_DIRECT_READ, .d(5'h11), .k(16'h0020)); pk(5'h11, 8'h85);
  endtask
  task t_stack;
    op(OP_PUSH); cw(16'hffff, 8'hbb);
    op(OP_PUSH, .d(5'h11)); cw(16'hfffe, 8'h85);
    op(OP_POP, .d(5'h14)); pk(5'h14, 8'h85);
    op(OP_POP, .d(5'h14)); pk(5'h14, 8'hbb);
  endtask
  task t_code;
    li(5'h1e, 8'h40); li(5'h1f, 8'h00);
    op(OP_CODE_READ, .m(MODE_POST_INC), .im(1'b1)); pk(5'h00, 8'h51);
    op(OP_CODE_READ, .d(5'h18)); pk(5'h18, 8'h52);
    li(5'h00, 8'h34); li(5'h01, 8'h12);
    op(OP_CODE_WRITE); chk("caddr", 16'h0041, pw[31:16]);
    chk("cdata", 16'h1234, pw[15:0]);
  endtask
  task t_reset;
    op_valid = 1'b0;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    cs(8'h00);
    chk("rst addr", 16'hffff, dmem_addr);
    pk(5'h10, 8'h00);
    op(OP_PUSH); cw(16'hffff, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    op_valid = 1'b0;
    op_implicit = 1'b0;
    op_rd = 5'h00;
    op_rr = 5'h00;
    op_bit = 3'h0;
    op_imm = 16'h0000;
    op_code = OP_NOP;
    op_ptr = PTR_X;
    op_mode = MODE_PLAIN;
    failures = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk("rst addr", 16'hffff, dmem_addr);
    cs(8'h00);
    t_flags;
    t_shift;
    t_bits;
    t_io;
    t_ptr;
    t_stack;
    t_code;
    t_reset;
    conclude;
  end
endmodule
`default_nettype wire
